// file: pkg/svdc_defines.vh
// Constants of the supply voltage detect control block
`ifndef SVDC_DEFINES_VH
`define SVDC_DEFINES_VH

// -----------------------------------------------------------------
// Register byte addresses
// -----------------------------------------------------------------
`define SVDC_ADDR_W          4
`define SVDC_OFF_CTRL        4'h0
`define SVDC_OFF_STATUS      4'h4
`define SVDC_OFF_CLEAR       4'h8
`define SVDC_OFF_ENABLE      4'hc

// -----------------------------------------------------------------
// Control register fields
// -----------------------------------------------------------------
`define SVDC_BIT_EN          15
`define SVDC_BIT_IDLE        13
`define SVDC_BIT_DIR         7
`define SVDC_BIT_BGST        6
`define SVDC_BIT_IRST        5
`define SVDC_LVL_HI          3
`define SVDC_LVL_LO          0
`define SVDC_CTRL_WMASK      16'ha08f
`define SVDC_CTRL_RST        16'h0000
`define SVDC_LVL_EXT         4'hf

// -----------------------------------------------------------------
// Interrupt bits
// -----------------------------------------------------------------
`define SVDC_IRQ_W           2
`define SVDC_IRQ_TRIP        0
`define SVDC_IRQ_UNSTABLE    1
`define SVDC_IRQ_RST         2'h0

`endif

// file: hdl/svdc_sync.v
// Three-stage synchroniser for one asynchronous input
`timescale 1ns/10ps
module svdc_sync (
  input  wire ref_clk_i,
  input  wire arst_n_i,
  input  wire async_i,
  output reg  level_o
);
  reg s1;
  reg s2;
  reg s3;

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1      <= 1'b0;
      s2      <= 1'b0;
      s3      <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end
endmodule

// file: hdl/svdc_trip_eval.v
// Trip direction evaluation of the comparator result
`timescale 1ns/10ps
module svdc_trip_eval (
  input  wire ref_clk_i,
  input  wire arst_n_i,
  input  wire active_i,
  input  wire dir_i,
  input  wire above_i,
  output reg  event_o
);
  reg tripped;
  reg was_tripped;

  always @* begin
    if (dir_i) begin
      tripped = above_i;
    end else begin
      tripped = ~above_i;
    end
  end

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      was_tripped <= 1'b0;
      event_o     <= 1'b0;
    end else begin
      was_tripped <= active_i & tripped;
      event_o     <= active_i & tripped & ~was_tripped;
    end
  end
endmodule

// file: hdl/svdc_top.v
// Supply voltage detect control: register, trip logic, interrupt
//
// Functional notes
// - Bit 15 enables the detector
// - Bit 13 stops detector during idle
// - Direction 1: event at or above trip
// - Direction 0: event below trip
// - Bit 6 reports band gap stable
// - Reference stable allows trip interrupt flag generation
// - Level 1111 selects external trip input
// - Codes 1110 to 0000 select points 1-15
// - Unimplemented bits read zero, ignore writes
`timescale 1ns/10ps
`include "svdc_defines.vh"
module svdc_top (
  input  wire        ref_clk_i,
  input  wire        arst_n_i,
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  input  wire        idle_mode_i,
  input  wire        bandgap_stable_i,
  input  wire        reference_stable_i,
  input  wire        comp_above_i,
  output reg         detector_power_o,
  output reg         ext_input_select_o,
  output reg  [3:0]  trip_point_o,
  output reg         irq_o
);

  // ---------------------------------------------------------------
  // Synchronised analog status inputs
  // ---------------------------------------------------------------
  wire [2:0] async_in;
  wire [2:0] synced;
  wire       bg_stable;
  wire       ir_stable;
  wire       above;

  assign async_in  = {comp_above_i, reference_stable_i, bandgap_stable_i};
  assign bg_stable = synced[0];
  assign ir_stable = synced[1];
  assign above     = synced[2];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      svdc_sync u_sync (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .async_i   (async_in[gi]),
        .level_o   (synced[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  reg  [15:0] ctrl;
  reg  [1:0]  irq_status;
  reg  [1:0]  irq_enable;
  wire        access;
  wire        wr;
  wire        sel_ctrl;
  wire        sel_status;
  wire        sel_clear;
  wire        sel_enable;
  wire        wr_ctrl;
  wire        wr_clear;
  wire        wr_enable;
  wire [15:0] be_mask;
  wire [15:0] wdata_mask;

  assign access     = (avs_read_i | avs_write_i) & avs_waitrequest_o;
  assign wr         = avs_write_i & avs_waitrequest_o;

  // ---------------------------------------------------------------
  // Address select and write strobes
  // ---------------------------------------------------------------
  assign sel_ctrl   = (avs_address_i == `SVDC_OFF_CTRL);
  assign sel_status = (avs_address_i == `SVDC_OFF_STATUS);
  assign sel_clear  = (avs_address_i == `SVDC_OFF_CLEAR);
  assign sel_enable = (avs_address_i == `SVDC_OFF_ENABLE);
  assign wr_ctrl    = wr & sel_ctrl;
  assign wr_clear   = wr & sel_clear & avs_byteenable_i[0];
  assign wr_enable  = wr & sel_enable & avs_byteenable_i[0];

  // ---------------------------------------------------------------
  // Byte lane masks
  // ---------------------------------------------------------------
  assign be_mask    = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wdata_mask = be_mask & `SVDC_CTRL_WMASK;

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl <= `SVDC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= (ctrl & ~wdata_mask) |
              (avs_writedata_i[15:0] & wdata_mask);
    end
  end

  // ---------------------------------------------------------------
  // Detector control
  // ---------------------------------------------------------------
  wire [3:0] level;
  wire       active;
  wire       trip_event;

  assign level  = ctrl[`SVDC_LVL_HI:`SVDC_LVL_LO];
  assign active = ctrl[`SVDC_BIT_EN] &
                  ~(ctrl[`SVDC_BIT_IDLE] & idle_mode_i);

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      detector_power_o   <= 1'b0;
      ext_input_select_o <= 1'b0;
      trip_point_o       <= 4'h0;
    end else begin
      detector_power_o   <= active;
      ext_input_select_o <= (level == `SVDC_LVL_EXT);
      trip_point_o       <= `SVDC_LVL_EXT - level;
    end
  end

  svdc_trip_eval u_eval (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .active_i  (active),
    .dir_i     (ctrl[`SVDC_BIT_DIR]),
    .above_i   (above),
    .event_o   (trip_event)
  );

  // ---------------------------------------------------------------
  // Interrupt status, clear and enable
  // ---------------------------------------------------------------
  reg        ir_prev;
  wire [1:0] events;
  wire [1:0] clr;

  assign events = {ir_prev & ~ir_stable & ctrl[`SVDC_BIT_EN],
                   trip_event & ir_stable};
  assign clr    = wr_clear ? avs_writedata_i[1:0] : 2'h0;

  // Set wins over clear in the same cycle
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ir_prev    <= 1'b0;
      irq_status <= `SVDC_IRQ_RST;
    end else begin
      ir_prev    <= ir_stable;
      irq_status <= (irq_status & ~clr) | events;
    end
  end

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_enable <= `SVDC_IRQ_RST;
    end else if (wr_enable) begin
      irq_enable <= avs_writedata_i[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Level interrupt output
  // ---------------------------------------------------------------
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_enable);
    end
  end

  // ---------------------------------------------------------------
  // Read path and waitrequest
  // ---------------------------------------------------------------
  reg [31:0] next_rdata;

  always @* begin
    next_rdata = 32'h0000_0000;
    case (avs_address_i)
      `SVDC_OFF_CTRL: begin
        next_rdata[15:0] = ctrl & `SVDC_CTRL_WMASK;
        next_rdata[`SVDC_BIT_BGST] = bg_stable;
        next_rdata[`SVDC_BIT_IRST] = ir_stable;
      end
      `SVDC_OFF_STATUS: begin
        next_rdata[1:0] = irq_status;
      end
      `SVDC_OFF_ENABLE: begin
        next_rdata[1:0] = irq_enable;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Answer sequencer: one wait cycle, one answer cycle
  // ---------------------------------------------------------------
  localparam ST_IDLE   = 1'b0;
  localparam ST_ANSWER = 1'b1;

  reg state;
  reg next_state;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (access) begin
          next_state = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state             <= ST_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      state             <= next_state;
      avs_waitrequest_o <= (next_state != ST_ANSWER);
      if (access && avs_read_i) begin
        avs_readdata_o <= next_rdata;
      end
    end
  end

endmodule

// file: tb/svdc_top_monitor.sv
// Checker of the detect control block ports
`timescale 1ns/10ps
module svdc_top_monitor (
  input wire        ref_clk_i,
  input wire        arst_n_i,
  input wire [3:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire        idle_mode_i,
  input wire        detector_power_o,
  input wire        ext_input_select_o,
  input wire [3:0]  trip_point_o
);
  reg       en;
  reg       halt;
  reg [3:0] lvl;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // --
  // Shadow of control fields
  // --
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {en, halt, lvl} <= 6'h00;
    end else if (avs_write_i && avs_waitrequest_o && avs_address_i == 4'h0) begin
      if (avs_byteenable_i[1]) {en, halt} <= {avs_writedata_i[15],
                                              avs_writedata_i[13]};
      if (avs_byteenable_i[0]) lvl <= avs_writedata_i[3:0];
    end
  end
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_rd_ctrl;
    avs_read_i && avs_waitrequest_o && avs_address_i == 4'h0;
  endsequence
  property p_ans; s_req |=> !avs_waitrequest_o; endproperty
  property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  property p_rd; s_rd_ctrl |=> (avs_readdata_o & 32'hffff5f10) == 0;
  endproperty
  property p_on; (en && !(halt && idle_mode_i))[*3] |-> detector_power_o;
  endproperty
  property p_off; (!en)[*3] |-> !detector_power_o; endproperty
  property p_halt; (en && halt && idle_mode_i)[*3] |-> !detector_power_o;
  endproperty
  property p_lvl; $stable(lvl) && $past(arst_n_i, 2)
    |-> trip_point_o == 4'hf - lvl; endproperty
  property p_ext; $stable(lvl) && $past(arst_n_i, 2)
    |-> ext_input_select_o == (lvl == 4'hf); endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  a_one: assert property (p_one) else $error("long answer");
  a_rd: assert property (p_rd) else $error("bad unused bits");
  a_on: assert property (p_on) else $error("detector off");
  a_off: assert property (p_off) else $error("detector on");
  a_halt: assert property (p_halt) else $error("runs in idle");
  a_lvl: assert property (p_lvl) else $error("bad trip point");
  a_ext: assert property (p_ext) else $error("bad ext select");
endmodule

// file: tb/svdc_analog_model.sv
// Behavioural comparator and reference model
`timescale 1ns/10ps
module svdc_analog_model #(
  parameter SETTLE  = 8,
  parameter EXT_THR = 8
) (
  input  wire       ref_clk_i,
  input  wire       power_i,
  input  wire       ext_sel_i,
  input  wire [3:0] point_i,
  input  wire [4:0] volt_i,
  output wire       above_o,
  output wire       bg_stable_o,
  output wire       ref_stable_o
);
  integer cnt = 0;
  always @(posedge ref_clk_i) begin
    cnt <= power_i ? (cnt < SETTLE ? cnt + 1 : cnt) : 0;
  end
  assign bg_stable_o  = cnt >= SETTLE / 2;
  assign ref_stable_o = cnt >= SETTLE;
  assign above_o = volt_i >= (ext_sel_i ? EXT_THR : 16 - point_i);
endmodule

// file: tb/svdc_top_tb_top.sv
// Testbench top of the detect control block
`timescale 1ns/10ps
module svdc_top_tb_top;
  reg         ref_clk_i = 0, arst_n_i = 0, avs_read_i = 0, avs_write_i = 0;
  reg         idle_mode_i = 0;
  reg  [3:0]  avs_address_i = 0, avs_byteenable_i = 4'h3;
  reg  [31:0] avs_writedata_i = 0, q;
  reg  [4:0]  volt = 0;
  wire [31:0] avs_readdata_o;
  wire        avs_waitrequest_o, detector_power_o, ext_input_select_o, irq_o;
  wire        comp_above_i, bandgap_stable_i, reference_stable_i;
  wire [3:0]  trip_point_o;
  integer     n_errors = 0, tests_run = 0, seed = 65182, i, c;
  always #25 ref_clk_i = ~ref_clk_i;
  svdc_top i_dut (.ref_clk_i, .arst_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .idle_mode_i, .bandgap_stable_i, .reference_stable_i,
    .comp_above_i, .detector_power_o, .ext_input_select_o, .trip_point_o,
    .irq_o);
  svdc_analog_model i_ana (.ref_clk_i, .power_i(detector_power_o),
    .ext_sel_i(ext_input_select_o), .point_i(trip_point_o), .volt_i(volt),
    .above_o(comp_above_i), .bg_stable_o(bandgap_stable_i),
    .ref_stable_o(reference_stable_i));
  task chk(input [39:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    integer t;
    begin
      t = 0;
      avs_read_i <= !w; avs_write_i <= w;
      avs_address_i <= a; avs_writedata_i <= d;
      @(posedge ref_clk_i);
      while (avs_waitrequest_o !== 1'b0 && t < 20) begin
        @(posedge ref_clk_i); t = t + 1;
      end
      if (t >= 20) n_errors = n_errors + 1;
      q = avs_readdata_o; avs_read_i <= 0; avs_write_i <= 0;
      @(posedge ref_clk_i);
    end
  endtask
  task trip(input dir, input [3:0] code, input ie);
    integer th;
    begin
      th = (code == 4'hf) ? 8 : code + 1;
      volt <= dir ? th - 1 : th;
      bus(1, 4'h0, {16'h0, 1'b1, 7'h0, dir, 3'h0, code});
      repeat (12) @(posedge ref_clk_i);
      bus(1, 4'h8, 32'h3);
      volt <= dir ? th : th - 1;
      repeat (10) @(posedge ref_clk_i);
      bus(0, 4'h4, 0); chk("trip", q[0], 1);
      chk("irq", irq_o, ie);
      bus(1, 4'h8, 32'h1); bus(0, 4'h4, 0); chk("clear", q[0], 0);
      chk("irq", irq_o, 0);
    end
  endtask
  task tally_and_finish;
    begin
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    #1000000; n_errors = n_errors + 1; tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge ref_clk_i);
    arst_n_i <= 1;
    bus(0, 4'h0, 0); chk("reset", q, 0);
    bus(1, 4'h0, 32'hffff); bus(0, 4'h0, 0);
    chk("ctrl", q & 32'hffffff9f, 32'ha08f);
    repeat (20) @(posedge ref_clk_i);
    bus(0, 4'h0, 0); chk("flags", q[6:5], 2'h3);
    idle_mode_i <= 1; repeat (4) @(posedge ref_clk_i);
    chk("idle", detector_power_o, 0);
    idle_mode_i <= 0; bus(0, 4'h1, 0); chk("unmap", q, 0);
    for (c = 0; c < 16; c = c + 1) begin
      bus(1, 4'h0, c); @(posedge ref_clk_i);
      chk("level", {ext_input_select_o, trip_point_o},
          {c == 15, 4'hf - c[3:0]});
      chk("power", detector_power_o, 0);
    end
    bus(1, 4'h0, 32'h8000); repeat (20) @(posedge ref_clk_i);
    bus(1, 4'hc, 32'h1);
    trip(1, 4'h3, 1); trip(0, 4'h0, 1); trip(1, 4'hf, 1); trip(0, 4'he, 1);
    for (i = 0; i < 6; i = i + 1) trip($random(seed), $random(seed), 1);
    bus(1, 4'hc, 0); trip(1, 4'h5, 0);
    tally_and_finish;
  end
endmodule
bind svdc_top svdc_top_monitor i_mon (.ref_clk_i, .arst_n_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
  .avs_readdata_o, .avs_waitrequest_o, .idle_mode_i, .detector_power_o,
  .ext_input_select_o, .trip_point_o);
